// ---- hdl/ctc_map.vh ----
// Register map, field positions, reset values and timing constants of the charge timer control block
`ifndef CTC_MAP_VH
`define CTC_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CTC_ADDR_PRECHARGE_TIMER 8'h0d
`define CTC_ADDR_TIMER_CONTROL 8'h0e
`define CTC_ADDR_CHARGER_CONTROL_ZERO 8'h0f
`define CTC_ADDR_CHARGER_CONTROL_ONE 8'h10

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define CTC_RST_PRECHARGE_TIMER 8'h4b
`define CTC_RST_TIMER_CONTROL 8'h3d
`define CTC_RST_CHARGER_CONTROL_ZERO 8'ha2
`define CTC_RST_CHARGER_CONTROL_ONE 8'h85
`define CTC_WMASK_PRECHARGE_TIMER 8'h80
`define CTC_WMASK_CHARGER_CONTROL_ZERO 8'hfe
`define CTC_WMASK_CHARGER_CONTROL_ONE 8'h3f

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTC_PRECHARGE_LENGTH_BIT 7
`define CTC_TOPOFF_HI 7
`define CTC_TOPOFF_LO 6
`define CTC_TRICKLE_EN_BIT 5
`define CTC_PRECHARGE_EN_BIT 4
`define CTC_FAST_EN_BIT 3
`define CTC_FAST_LEN_HI 2
`define CTC_FAST_LEN_LO 1
`define CTC_HALF_SPEED_BIT 0
`define CTC_AUTO_DISCHARGE_BIT 7
`define CTC_FORCED_DISCHARGE_BIT 6
`define CTC_CHARGING_EN_BIT 5
`define CTC_OPTIMIZER_EN_BIT 4
`define CTC_OPTIMIZER_START_BIT 3
`define CTC_HIZ_BIT 2
`define CTC_TERM_EN_BIT 1
`define CTC_KICK_BIT 3
`define CTC_WD_HI 2
`define CTC_WD_LO 0

// ---------------------------------------------------------------
// Charge phases reported by the charger core
// ---------------------------------------------------------------
`define CTC_PHASE_IDLE 3'h0
`define CTC_PHASE_TRICKLE 3'h1
`define CTC_PHASE_PRECHARGE 3'h2
`define CTC_PHASE_FAST 3'h3
`define CTC_PHASE_TOPOFF 3'h4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CTC_CLK_PERIOD_NS 20
`define CTC_TICK_MS 500
`define CTC_TICKS_PER_MIN 18'h00078
`define CTC_TRICKLE_MIN 11'h03c
`define CTC_PRECHARGE_LONG_MIN 11'h078
`define CTC_PRECHARGE_SHORT_MIN 11'h01e
`define CTC_FAST_5H_MIN 11'h12c
`define CTC_FAST_8H_MIN 11'h1e0
`define CTC_FAST_12H_MIN 11'h2d0
`define CTC_FAST_24H_MIN 11'h5a0
`define CTC_TOPOFF_STEP_MIN 11'h00f
`define CTC_WD_0P5S_TICKS 9'h001
`define CTC_WD_1S_TICKS 9'h002
`define CTC_WD_2S_TICKS 9'h004
`define CTC_WD_20S_TICKS 9'h028
`define CTC_WD_40S_TICKS 9'h050
`define CTC_WD_80S_TICKS 9'h0a0
`define CTC_WD_160S_TICKS 9'h140

`endif

// ---- hdl/ctc_regs.v ----
// Charger safety timer and charge control register bank
`include "ctc_map.vh"
`timescale 1ns/10ps
`default_nettype none

module ctc_regs #(
	parameter TICK_CYCLES = (`CTC_TICK_MS * 1000000) / `CTC_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire i_clk,
	input wire i_reset_n,
	// Register access port
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_rd,
	output reg [7:0] o_reg_rdata,
	// Charger core status
	input wire [2:0] i_charge_phase,
	input wire i_dpm_or_thermal,
	input wire i_battery_ovp,
	input wire i_adapter_present,
	input wire i_optimizer_started,
	input wire i_register_reset,
	// Controls to charger core
	output reg o_charging_enable,
	output reg o_termination_enable,
	output reg o_discharge_on,
	output reg o_optimizer_enable,
	output reg o_optimizer_start,
	output reg o_high_impedance_input,
	output reg o_safety_timer_expired,
	output reg o_topoff_done,
	output reg o_watchdog_expired
);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function [17:0] ctc_min_to_ticks;
		input [10:0] minutes;
		begin
			ctc_min_to_ticks = minutes * `CTC_TICKS_PER_MIN;
		end
	endfunction

	function [8:0] ctc_wd_ticks;
		input [2:0] code;
		begin
			case (code)
				3'h1: ctc_wd_ticks = `CTC_WD_0P5S_TICKS;
				3'h2: ctc_wd_ticks = `CTC_WD_1S_TICKS;
				3'h3: ctc_wd_ticks = `CTC_WD_2S_TICKS;
				3'h4: ctc_wd_ticks = `CTC_WD_20S_TICKS;
				3'h5: ctc_wd_ticks = `CTC_WD_40S_TICKS;
				3'h6: ctc_wd_ticks = `CTC_WD_80S_TICKS;
				3'h7: ctc_wd_ticks = `CTC_WD_160S_TICKS;
				default: ctc_wd_ticks = 9'h000;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	localparam [7:0] RST_CTL0 = `CTC_RST_CHARGER_CONTROL_ZERO;
	reg [7:0] prechg_q;
	reg [7:0] timer_ctl_q;
	reg [7:0] ctl0_q;
	reg [7:0] ctl1_q;
	reg [31:0] tick_cnt_q;
	reg tick_q;
	reg [8:0] wd_cnt_q;
	reg [17:0] safety_cnt_q;
	reg [2:0] phase_q;
	reg half_q;
	reg adapter_q;

	wire wr_prechg = i_reg_wr && (i_reg_addr == `CTC_ADDR_PRECHARGE_TIMER);
	wire wr_timer = i_reg_wr && (i_reg_addr == `CTC_ADDR_TIMER_CONTROL);
	wire wr_ctl0 = i_reg_wr && (i_reg_addr == `CTC_ADDR_CHARGER_CONTROL_ZERO);
	wire wr_ctl1 = i_reg_wr && (i_reg_addr == `CTC_ADDR_CHARGER_CONTROL_ONE);
	wire kick = wr_ctl1 && i_reg_wdata[`CTC_KICK_BIT];
	wire [8:0] wd_limit = ctc_wd_ticks(ctl1_q[`CTC_WD_HI:`CTC_WD_LO]);
	wire wd_fire = (wd_limit != 9'h000) && tick_q && (wd_cnt_q + 9'h001 >= wd_limit) && !kick;
	wire adapter_new = i_adapter_present && !adapter_q;

	// ---------------------------------------------------------------
	// Half-second tick
	// ---------------------------------------------------------------
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Host watchdog
	// ---------------------------------------------------------------
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wd_cnt_q <= 9'h000;
			o_watchdog_expired <= 1'b0;
		end else if (kick || i_register_reset || wd_limit == 9'h000) begin
			wd_cnt_q <= 9'h000;
			o_watchdog_expired <= 1'b0;
		end else if (wd_fire) begin
			wd_cnt_q <= 9'h000;
			o_watchdog_expired <= 1'b1;
		end else begin
			if (tick_q)
				wd_cnt_q <= wd_cnt_q + 9'h001;
			o_watchdog_expired <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prechg_q <= `CTC_RST_PRECHARGE_TIMER;
			timer_ctl_q <= `CTC_RST_TIMER_CONTROL;
			ctl0_q <= `CTC_RST_CHARGER_CONTROL_ZERO;
			ctl1_q <= `CTC_RST_CHARGER_CONTROL_ONE;
			adapter_q <= 1'b0;
		end else begin
			adapter_q <= i_adapter_present;
			if (i_register_reset) begin
				prechg_q <= `CTC_RST_PRECHARGE_TIMER;
				timer_ctl_q <= `CTC_RST_TIMER_CONTROL;
				ctl0_q <= `CTC_RST_CHARGER_CONTROL_ZERO;
				ctl1_q <= `CTC_RST_CHARGER_CONTROL_ONE;
			end else if (wd_fire) begin
				prechg_q <= `CTC_RST_PRECHARGE_TIMER;
				timer_ctl_q <= `CTC_RST_TIMER_CONTROL;
				ctl0_q[`CTC_CHARGING_EN_BIT] <= RST_CTL0[`CTC_CHARGING_EN_BIT];
				ctl0_q[`CTC_OPTIMIZER_START_BIT] <= 1'b0;
				ctl0_q[`CTC_TERM_EN_BIT] <= RST_CTL0[`CTC_TERM_EN_BIT];
				ctl1_q[`CTC_KICK_BIT] <= 1'b0;
				if (adapter_new)
					ctl0_q[`CTC_HIZ_BIT] <= 1'b0;
			end else begin
				if (wr_prechg)
					prechg_q <= (i_reg_wdata & `CTC_WMASK_PRECHARGE_TIMER) |
						(`CTC_RST_PRECHARGE_TIMER & ~`CTC_WMASK_PRECHARGE_TIMER);
				if (wr_timer)
					timer_ctl_q <= i_reg_wdata;
				if (adapter_new)
					ctl0_q[`CTC_HIZ_BIT] <= 1'b0;
				if (i_optimizer_started)
					ctl0_q[`CTC_OPTIMIZER_START_BIT] <= 1'b0;
				if (wr_ctl0) begin
					ctl0_q[7:4] <= i_reg_wdata[7:4];
					ctl0_q[`CTC_TERM_EN_BIT] <= i_reg_wdata[`CTC_TERM_EN_BIT];
					if (!adapter_new || i_reg_wdata[`CTC_HIZ_BIT])
						ctl0_q[`CTC_HIZ_BIT] <= i_reg_wdata[`CTC_HIZ_BIT];
					if (i_reg_wdata[`CTC_OPTIMIZER_START_BIT] && i_reg_wdata[`CTC_OPTIMIZER_EN_BIT])
						ctl0_q[`CTC_OPTIMIZER_START_BIT] <= 1'b1;
				end
				if (!i_reg_wdata[`CTC_OPTIMIZER_EN_BIT] && wr_ctl0)
					ctl0_q[`CTC_OPTIMIZER_START_BIT] <= 1'b0;
				if (wr_ctl1)
					ctl1_q <= ((i_reg_wdata & `CTC_WMASK_CHARGER_CONTROL_ONE) |
						(`CTC_RST_CHARGER_CONTROL_ONE & ~`CTC_WMASK_CHARGER_CONTROL_ONE)) & 8'hf7;
			end
		end
	end

	// ---------------------------------------------------------------
	// Safety and top-off timers
	// ---------------------------------------------------------------
	reg [17:0] safety_limit;
	reg safety_run;
	always @* begin
		safety_limit = 18'h00000;
		safety_run = 1'b0;
		case (i_charge_phase)
			`CTC_PHASE_TRICKLE: begin
				safety_limit = ctc_min_to_ticks(`CTC_TRICKLE_MIN);
				safety_run = timer_ctl_q[`CTC_TRICKLE_EN_BIT];
			end
			`CTC_PHASE_PRECHARGE: begin
				safety_limit = prechg_q[`CTC_PRECHARGE_LENGTH_BIT] ?
					ctc_min_to_ticks(`CTC_PRECHARGE_SHORT_MIN) : ctc_min_to_ticks(`CTC_PRECHARGE_LONG_MIN);
				safety_run = timer_ctl_q[`CTC_PRECHARGE_EN_BIT];
			end
			`CTC_PHASE_FAST: begin
				case (timer_ctl_q[`CTC_FAST_LEN_HI:`CTC_FAST_LEN_LO])
					2'h0: safety_limit = ctc_min_to_ticks(`CTC_FAST_5H_MIN);
					2'h1: safety_limit = ctc_min_to_ticks(`CTC_FAST_8H_MIN);
					2'h2: safety_limit = ctc_min_to_ticks(`CTC_FAST_12H_MIN);
					default: safety_limit = ctc_min_to_ticks(`CTC_FAST_24H_MIN);
				endcase
				safety_run = timer_ctl_q[`CTC_FAST_EN_BIT];
			end
			`CTC_PHASE_TOPOFF: begin
				safety_limit = ctc_min_to_ticks({9'h000, timer_ctl_q[`CTC_TOPOFF_HI:`CTC_TOPOFF_LO]} *
					`CTC_TOPOFF_STEP_MIN);
				safety_run = (timer_ctl_q[`CTC_TOPOFF_HI:`CTC_TOPOFF_LO] != 2'h0);
			end
			default: begin
				safety_limit = 18'h00000;
				safety_run = 1'b0;
			end
		endcase
	end

	wire slow = timer_ctl_q[`CTC_HALF_SPEED_BIT] && i_dpm_or_thermal && (i_charge_phase != `CTC_PHASE_TOPOFF);
	wire advance = tick_q && safety_run && (!slow || half_q);
	wire restart = (i_charge_phase != phase_q) || i_register_reset;
	wire reached = safety_run && (safety_cnt_q >= safety_limit);

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_q <= `CTC_PHASE_IDLE;
			safety_cnt_q <= 18'h00000;
			half_q <= 1'b0;
			o_safety_timer_expired <= 1'b0;
			o_topoff_done <= 1'b0;
		end else begin
			phase_q <= i_charge_phase;
			if (tick_q && slow)
				half_q <= ~half_q;
			if (restart) begin
				safety_cnt_q <= 18'h00000;
				o_safety_timer_expired <= 1'b0;
				o_topoff_done <= 1'b0;
			end else begin
				if (advance && !reached)
					safety_cnt_q <= safety_cnt_q + 18'h00001;
				o_safety_timer_expired <= reached && (i_charge_phase != `CTC_PHASE_TOPOFF);
				o_topoff_done <= reached && (i_charge_phase == `CTC_PHASE_TOPOFF);
			end
		end
	end

	// ---------------------------------------------------------------
	// Control outputs and read data
	// ---------------------------------------------------------------
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_charging_enable <= 1'b0;
			o_termination_enable <= 1'b0;
			o_discharge_on <= 1'b0;
			o_optimizer_enable <= 1'b0;
			o_optimizer_start <= 1'b0;
			o_high_impedance_input <= 1'b0;
			o_reg_rdata <= 8'h00;
		end else begin
			o_charging_enable <= ctl0_q[`CTC_CHARGING_EN_BIT];
			o_termination_enable <= ctl0_q[`CTC_TERM_EN_BIT];
			o_discharge_on <= ctl0_q[`CTC_FORCED_DISCHARGE_BIT] ||
				(ctl0_q[`CTC_AUTO_DISCHARGE_BIT] && i_battery_ovp);
			o_optimizer_enable <= ctl0_q[`CTC_OPTIMIZER_EN_BIT];
			o_optimizer_start <= ctl0_q[`CTC_OPTIMIZER_START_BIT] && ctl0_q[`CTC_OPTIMIZER_EN_BIT];
			o_high_impedance_input <= ctl0_q[`CTC_HIZ_BIT];
			if (i_reg_rd) begin
				if (i_reg_addr == `CTC_ADDR_PRECHARGE_TIMER)
					o_reg_rdata <= prechg_q;
				else if (i_reg_addr == `CTC_ADDR_TIMER_CONTROL)
					o_reg_rdata <= timer_ctl_q;
				else if (i_reg_addr == `CTC_ADDR_CHARGER_CONTROL_ZERO)
					o_reg_rdata <= ctl0_q;
				else if (i_reg_addr == `CTC_ADDR_CHARGER_CONTROL_ONE)
					o_reg_rdata <= ctl1_q;
				else
					o_reg_rdata <= 8'h00;
			end
		end
	end

endmodule // ctc_regs

`default_nettype wire

// ---- test/ctc_host.sv ----
// Host controller model driving the register access port
`timescale 1ns/10ps
`default_nettype none
module ctc_host (
	// Clock
	input wire logic i_clk,
	// Register access
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wr = 1'b0;
		o_wdata = 8'h00;
		o_rd = 1'b0;
	end
	// Strobe held over one taking edge, data line scrambled once released
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
	endtask
	task kick(input logic [2:0] period);
		wr(8'h10, {4'h0, 1'b1, period});
	endtask
	task opt_start;
		wr(8'h0f, 8'h18);
	endtask
endmodule // ctc_host
`default_nettype wire

// ---- test/ctc_regs_asserts.sv ----
// Concurrent checks on the charge timer control register bank ports
`timescale 1ns/10ps
`default_nettype none
module ctc_regs_asserts (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	// Status and controls
	input wire logic i_battery_ovp,
	input wire logic i_adapter_present,
	input wire logic i_register_reset,
	input wire logic i_optimizer_started,
	input wire logic o_charging_enable,
	input wire logic o_termination_enable,
	input wire logic o_discharge_on,
	input wire logic o_optimizer_enable,
	input wire logic o_optimizer_start,
	input wire logic o_high_impedance_input,
	input wire logic o_watchdog_expired
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// Control register write that was not dropped
	sequence s_wr_ctl;
		i_reg_wr && i_reg_addr == 8'h0f && !i_register_reset ##1 !o_watchdog_expired && !i_register_reset;
	endsequence
	AST_CHG_EN: assert property (s_wr_ctl |=> o_charging_enable == $past(i_reg_wdata[5], 2))
		else $error("charge enable does not follow write");
	AST_TERM_EN: assert property (s_wr_ctl |=> o_termination_enable == $past(i_reg_wdata[1], 2))
		else $error("termination enable does not follow write");
	AST_OPT_EN: assert property (s_wr_ctl |=> o_optimizer_enable == $past(i_reg_wdata[4], 2))
		else $error("optimizer enable does not follow write");
	AST_DISCHARGE: assert property (s_wr_ctl |=> o_discharge_on ==
		($past(i_reg_wdata[6], 2) | ($past(i_reg_wdata[7], 2) & $past(i_battery_ovp))))
		else $error("discharge output wrong");
	AST_UNMAPPED: assert property (i_reg_rd && (i_reg_addr < 8'h0d || i_reg_addr > 8'h10) |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RSVD_PRE: assert property (i_reg_rd && i_reg_addr == 8'h0d |=> o_reg_rdata[6:0] == 7'h4b)
		else $error("reserved precharge bits wrong");
	AST_RSVD_CTL: assert property (i_reg_rd && i_reg_addr == 8'h0f |=> !o_reg_rdata[0])
		else $error("reserved control bit set");
	AST_KICK_READ: assert property (i_reg_rd && i_reg_addr == 8'h10 |=> o_reg_rdata[7:6] == 2'h2 && !o_reg_rdata[3])
		else $error("kick or reserved bits read wrong");
	AST_WD_PULSE: assert property (o_watchdog_expired |=> !o_watchdog_expired)
		else $error("watchdog pulse too long");
	AST_OPT_START: assert property (o_optimizer_start |-> o_optimizer_enable)
		else $error("start without enable");
	AST_OPT_CLEAR: assert property (i_optimizer_started && !i_reg_wr |-> ##2 !o_optimizer_start)
		else $error("start kept after optimizer run began");
	AST_REG_RESET: assert property (i_register_reset |-> ##2 o_charging_enable && o_termination_enable
		&& !o_high_impedance_input && !o_optimizer_enable && !o_optimizer_start)
		else $error("register reset did not restore controls");
	AST_HIZ_ATTACH: assert property ($rose(i_adapter_present) && !i_reg_wr |-> ##[1:3] !o_high_impedance_input)
		else $error("high impedance kept after attach");
endmodule // ctc_regs_asserts
bind ctc_regs ctc_regs_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.i_battery_ovp(i_battery_ovp), .i_adapter_present(i_adapter_present), .i_register_reset(i_register_reset),
	.i_optimizer_started(i_optimizer_started),
	.o_charging_enable(o_charging_enable), .o_termination_enable(o_termination_enable),
	.o_discharge_on(o_discharge_on), .o_optimizer_enable(o_optimizer_enable), .o_optimizer_start(o_optimizer_start),
	.o_high_impedance_input(o_high_impedance_input), .o_watchdog_expired(o_watchdog_expired));
`default_nettype wire

// ---- test/ctc_regs_test.sv ----
// Self-checking testbench for the charge timer control register bank
`timescale 1ns/10ps
`default_nettype none
module ctc_regs_test;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [2:0] phase;
	logic dpm, ovp, adp, ostart, rreset, rd_pend;
	wire [7:0] addr, wdata, rdata;
	wire wr, rd, chg, term, dis, oen, ost, hiz, sexp, tdone, wexp;
	logic [7:0] exp_q[$];
	logic [7:0] v;
	int n_errors = 0;
	int n_tests = 0;
	int k;
	always #10 i_clk = ~i_clk;
	ctc_regs #(.TICK_CYCLES(4)) u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_charge_phase(phase), .i_dpm_or_thermal(dpm),
		.i_battery_ovp(ovp), .i_adapter_present(adp), .i_optimizer_started(ostart), .i_register_reset(rreset),
		.o_charging_enable(chg), .o_termination_enable(term), .o_discharge_on(dis), .o_optimizer_enable(oen),
		.o_optimizer_start(ost), .o_high_impedance_input(hiz), .o_safety_timer_expired(sexp),
		.o_topoff_done(tdone), .o_watchdog_expired(wexp));
	ctc_host u_host (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
	task close_out;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk_rd(input logic [7:0] got, input logic [7:0] e);
		n_tests++;
		if (got !== e) begin
			n_errors++;
			$display("[FAIL] %0t rdata %h expected %h", $time, got, e);
		end
	endtask
	task chk_bit(input logic got, input logic e);
		n_tests++;
		if (got !== e) begin
			n_errors++;
			$display("[FAIL] %0t output %h expected %h", $time, got, e);
		end
	endtask
	task rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.rd(a);
	endtask
	task pulse(input logic to_reset);
		@(posedge i_clk);
		if (to_reset)
			rreset <= 1'b1;
		else
			ostart <= 1'b1;
		@(posedge i_clk);
		rreset <= 1'b0;
		ostart <= 1'b0;
	endtask
	task run_tmr(input logic [2:0] ph, input int lim);
		int c;
		phase <= 3'h0;
		repeat (3) @(posedge i_clk);
		phase <= ph;
		c = 0;
		while ((ph == 3'h4 ? tdone : sexp) !== 1'b1 && c < lim + 16) begin
			@(posedge i_clk);
			c++;
		end
		chk_bit(c >= lim - 16 && c < lim + 16, 1'b1);
		if (c >= lim + 16) close_out();
	endtask
	task wait_wd;
		int c;
		c = 0;
		while (wexp !== 1'b1 && c < 40) begin
			@(posedge i_clk);
			c++;
		end
		chk_bit(c < 40, 1'b1);
		if (c >= 40) close_out();
	endtask
	// Read results are one cycle behind the strobe
	always @(posedge i_clk) rd_pend <= rd;
	always @(negedge i_clk) begin
		if (rd_pend === 1'b1) chk_rd(rdata, exp_q.pop_front());
	end
	initial begin
		{phase, dpm, ovp, adp, ostart, rreset} = 8'h00;
		v = $urandom(91559);
		repeat (10) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd_exp(8'h0d, 8'h4b);
		rd_exp(8'h0e, 8'h3d);
		rd_exp(8'h0f, 8'ha2);
		rd_exp(8'h10, 8'h85);
		rd_exp(8'h20, 8'h00);
		chk_bit(chg & term, 1'b1);
		u_host.wr(8'h10, 8'hff);
		rd_exp(8'h10, 8'hb7);
		u_host.wr(8'h10, 8'h00);
		rd_exp(8'h10, 8'h80);
		$display("test reset values done");
		for (k = 0; k < 8; k++) begin
			v = $urandom;
			ovp <= v[0];
			u_host.wr(8'h0e, v);
			rd_exp(8'h0e, v);
			u_host.wr(8'h0d, v);
			rd_exp(8'h0d, {v[7], 7'h4b});
			u_host.wr(8'h0f, v & 8'hf6);
			rd_exp(8'h0f, v & 8'hf6);
			@(posedge i_clk);
			chk_bit(chg, v[5]);
			chk_bit(term, v[1]);
			chk_bit(oen, v[4]);
			chk_bit(dis, v[6] | (v[7] & v[0]));
		end
		$display("test random fields done");
		u_host.wr(8'h0f, 8'h08);
		rd_exp(8'h0f, 8'h00);
		u_host.opt_start();
		rd_exp(8'h0f, 8'h18);
		chk_bit(ost, 1'b1);
		pulse(1'b0);
		rd_exp(8'h0f, 8'h10);
		u_host.wr(8'h0f, 8'h04);
		rd_exp(8'h0f, 8'h04);
		adp <= 1'b1;
		rd_exp(8'h0f, 8'h00);
		$display("test optimizer and attach done");
		u_host.wr(8'h0e, 8'h00);
		u_host.wr(8'h0f, 8'h54);
		u_host.wr(8'h10, 8'h02);
		repeat (6) u_host.kick(3'h2);
		rd_exp(8'h0e, 8'h00);
		wait_wd();
		rd_exp(8'h0e, 8'h3d);
		rd_exp(8'h0f, 8'h76);
		rd_exp(8'h10, 8'h82);
		u_host.wr(8'h10, 8'h00);
		u_host.wr(8'h0f, 8'hd4);
		pulse(1'b1);
		rd_exp(8'h0f, 8'ha2);
		rd_exp(8'h10, 8'h85);
		u_host.wr(8'h10, 8'h00);
		$display("test watchdog and reset done");
		u_host.wr(8'h0d, 8'h80);
		run_tmr(3'h2, 3600 * 4);
		dpm <= 1'b1;
		run_tmr(3'h2, 7200 * 4);
		dpm <= 1'b0;
		u_host.wr(8'h0e, 8'h7d);
		run_tmr(3'h4, 1800 * 4);
		u_host.wr(8'h0e, 8'h2d);
		phase <= 3'h0;
		repeat (3) @(posedge i_clk);
		phase <= 3'h2;
		repeat (3600 * 4 + 40) @(posedge i_clk);
		chk_bit(sexp, 1'b0);
		$display("test safety timers done");
		repeat (3) @(posedge i_clk);
		close_out();
	end
endmodule // ctc_regs_test
`default_nettype wire
